// file: bwc_pkg.sv
/*
 * Constants for the bridge window and control register bank: offsets, field positions, reset values and windows.
 * Assumes a 32-bit AXI4-Lite register bus and byte addressing of aligned words.
 */
package bwc_pkg;
	localparam int unsigned BWC_ADDR_W = 8;
	localparam logic [7:0] BWC_OFS_PF_BASE_HI = 8'h28;
	localparam logic [7:0] BWC_OFS_PF_LIMIT_HI = 8'h2c;
	localparam logic [7:0] BWC_OFS_IO_HI = 8'h30;
	localparam logic [7:0] BWC_OFS_CAP_PTR = 8'h34;
	localparam logic [7:0] BWC_OFS_IRQ_CTRL = 8'h3c;
	localparam logic [7:0] BWC_OFS_EVT_STATUS = 8'h80;
	localparam logic [7:0] BWC_OFS_EVT_MASK = 8'h84;
	localparam logic [31:0] BWC_RST_PF_HI = 32'h0000_0000;
	localparam logic [15:0] BWC_RST_IO_HI = 16'h0000;
	localparam logic [7:0] BWC_CAP_PTR_VALUE = 8'h40;
	localparam logic [7:0] BWC_RST_IRQ_LINE = 8'h00;
	localparam logic [7:0] BWC_RST_IRQ_PIN = 8'h00;
	localparam logic [3:0] BWC_RST_CTRL = 4'h0;
	localparam logic [3:0] BWC_PF_ADDR64 = 4'h1;
	localparam int unsigned BWC_CTRL_POISON = 16;
	localparam int unsigned BWC_CTRL_ERRFWD = 17;
	localparam int unsigned BWC_CTRL_ISA = 18;
	localparam int unsigned BWC_CTRL_VGA = 19;
	localparam logic [19:0] BWC_PF_LIMIT_LOW = 20'hf_ffff;
	localparam logic [63:0] BWC_VGA_MEM_LO = 64'h0000_0000_000a_0000;
	localparam logic [63:0] BWC_VGA_MEM_HI = 64'h0000_0000_000b_ffff;
	localparam logic [9:0] BWC_VGA_IO_A_LO = 10'h3b0;
	localparam logic [9:0] BWC_VGA_IO_A_HI = 10'h3bb;
	localparam logic [9:0] BWC_VGA_IO_B_LO = 10'h3c0;
	localparam logic [9:0] BWC_VGA_IO_B_HI = 10'h3df;
	localparam logic [31:0] BWC_IO_64K = 32'h0001_0000;
	localparam int unsigned BWC_EVT_W = 4;
	localparam int unsigned BWC_EVT_POISON = 0;
	localparam int unsigned BWC_EVT_ERRFWD = 1;
	localparam int unsigned BWC_EVT_ERRBLK = 2;
	localparam int unsigned BWC_EVT_HOTPLUG = 3;
	localparam logic [BWC_EVT_W-1:0] BWC_RST_MASK = 4'h0;
	localparam logic [1:0] BWC_RESP_OKAY = 2'b00;
	localparam logic [1:0] BWC_RESP_SLVERR = 2'b10;
endpackage

// file: bwc_regs.sv
/*
 * Bridge window and control register bank of one switch port, with its forwarding decision and event interrupt.
 * Assumes one 125 MHz clock; request, error and override inputs come from logic on the same clock.
 */
// What this block does
// - Writable 32-bit prefetch window base bits 63:32, reset zero.
// - Writable 32-bit prefetch window limit bits 63:32, reset zero.
// - I/O window base bits 31:16 in word bits 15:0, reset zero.
// - I/O window limit bits 31:16 in word bits 31:16, reset zero.
// - Capability pointer reads 40h and ignores writes.
// - Hot-plug events signalled on INTA; interrupt pin byte resets zero.
// - Downstream port may load interrupt pin value before software reads it.
// - Control bit 16 enables poisoned TLP detection and reporting; else ignored.
// - Control bit 17 enables error message forwarding upstream; else blocked.
// - Bit 18 clear forwards all I/O window addresses downstream.
// - Bit 18 set sends I/O window addresses in top 768 bytes of each 1KB below 64KB upstream; VGA I/O with bit 19 set still goes down.
// - Control bit 19 forwards VGA memory and I/O ranges; else ignored.
// - VGA memory range is 000A0000h through 000BFFFFh inclusive.
// - VGA I/O is below 64KB with low bits 3B0h-3BBh or 3C0h-3DFh.
// - Prefetch limit low twenty address bits are taken as all ones.
// - Prefetch window reports 64-bit addressing with field value 1h.
`timescale 1ns/1ps
module bwc_regs
	import bwc_pkg::*;
#(
	parameter bit IS_DOWNSTREAM = 1'b1
)
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic [BWC_ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [BWC_ADDR_W-1:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	input wire logic [11:0] pf_base_low_in,
	input wire logic [11:0] pf_limit_low_in,
	input wire logic [3:0] io_base_low_in,
	input wire logic [3:0] io_limit_low_in,
	input wire logic req_valid_in,
	input wire logic req_is_io_in,
	input wire logic [63:0] req_addr_in,
	output logic fwd_valid_out,
	output logic fwd_down_out,
	output logic fwd_up_out,
	input wire logic poisoned_tlp_in,
	output logic poison_report_out,
	input wire logic err_msg_valid_in,
	output logic err_msg_forward_out,
	input wire logic hotplug_event_in,
	input wire logic pin_load_valid_in,
	input wire logic [7:0] pin_load_value_in,
	output logic [3:0] pf_addr_cap_out,
	output logic irq_out
);
	logic [31:0] pf_base_hi;
	logic [31:0] pf_limit_hi;
	logic [15:0] io_base_hi;
	logic [15:0] io_limit_hi;
	logic [7:0] irq_line;
	logic [7:0] irq_pin;
	logic pin_locked;
	logic [3:0] ctrl;
	logic [BWC_EVT_W-1:0] evt_status;
	logic [BWC_EVT_W-1:0] evt_mask;

	logic aw_held;
	logic w_held;
	logic [BWC_ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_fire;
	logic rd_fire;
	logic [31:0] next_rdata;
	logic rd_mapped;
	logic wr_mapped;
	logic [31:0] io_merged;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[i*8 +: 8] = data[i*8 +: 8];
		return res;
	endfunction

	// Write address and data are taken independently and held until both are present.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			aw_held <= 1'b0;
			aw_addr <= '0;
		end
		else if (s_axi_awvalid_in && s_axi_awready_out)
		begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr_in;
		end
		else if (wr_fire)
			aw_held <= 1'b0;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			w_held <= 1'b0;
			w_data <= '0;
			w_strb <= '0;
		end
		else if (s_axi_wvalid_in && s_axi_wready_out)
		begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata_in;
			w_strb <= s_axi_wstrb_in;
		end
		else if (wr_fire)
			w_held <= 1'b0;
	end

	assign wr_fire = aw_held && w_held && !s_axi_bvalid_out;
	assign io_merged = merge({io_limit_hi, io_base_hi}, w_data, w_strb);

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end
		else
		begin
			s_axi_awready_out <= !aw_held && !(s_axi_awvalid_in && s_axi_awready_out) && !s_axi_bvalid_out;
			s_axi_wready_out <= !w_held && !(s_axi_wvalid_in && s_axi_wready_out) && !s_axi_bvalid_out;
		end
	end

	always_comb
	begin
		case (aw_addr)
			BWC_OFS_PF_BASE_HI, BWC_OFS_PF_LIMIT_HI, BWC_OFS_IO_HI, BWC_OFS_CAP_PTR,
			BWC_OFS_IRQ_CTRL, BWC_OFS_EVT_STATUS, BWC_OFS_EVT_MASK: wr_mapped = 1'b1;
			default: wr_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= BWC_RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= wr_mapped ? BWC_RESP_OKAY : BWC_RESP_SLVERR;
		end
		else if (s_axi_bready_in)
			s_axi_bvalid_out <= 1'b0;
	end

	// Window upper halves.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pf_base_hi <= BWC_RST_PF_HI;
			pf_limit_hi <= BWC_RST_PF_HI;
			io_base_hi <= BWC_RST_IO_HI;
			io_limit_hi <= BWC_RST_IO_HI;
		end
		else if (wr_fire)
		begin
			if (aw_addr == BWC_OFS_PF_BASE_HI)
				pf_base_hi <= merge(pf_base_hi, w_data, w_strb);
			if (aw_addr == BWC_OFS_PF_LIMIT_HI)
				pf_limit_hi <= merge(pf_limit_hi, w_data, w_strb);
			if (aw_addr == BWC_OFS_IO_HI)
			begin
				io_base_hi <= io_merged[15:0];
				io_limit_hi <= io_merged[31:16];
			end
		end
	end

	// Interrupt line byte and the four forwarding control bits; pin byte is read-only.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_line <= BWC_RST_IRQ_LINE;
			ctrl <= BWC_RST_CTRL;
		end
		else if (wr_fire && aw_addr == BWC_OFS_IRQ_CTRL)
		begin
			if (w_strb[0])
				irq_line <= w_data[7:0];
			if (w_strb[2])
				ctrl <= w_data[BWC_CTRL_VGA:BWC_CTRL_POISON];
		end
	end

	// A loaded pin value is taken only on a downstream port and only until software first reads it.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_pin <= BWC_RST_IRQ_PIN;
			pin_locked <= 1'b0;
		end
		else
		begin
			if (IS_DOWNSTREAM && pin_load_valid_in && !pin_locked)
				irq_pin <= pin_load_value_in;
			if (rd_fire && s_axi_araddr_in == BWC_OFS_IRQ_CTRL)
				pin_locked <= 1'b1;
		end
	end

	// Read channel.
	assign rd_fire = s_axi_arvalid_in && s_axi_arready_out;

	always_comb
	begin
		next_rdata = '0;
		rd_mapped = 1'b1;
		case (s_axi_araddr_in)
			BWC_OFS_PF_BASE_HI: next_rdata = pf_base_hi;
			BWC_OFS_PF_LIMIT_HI: next_rdata = pf_limit_hi;
			BWC_OFS_IO_HI: next_rdata = {io_limit_hi, io_base_hi};
			BWC_OFS_CAP_PTR: next_rdata = {24'h00_0000, BWC_CAP_PTR_VALUE};
			BWC_OFS_IRQ_CTRL: next_rdata = {12'h000, ctrl, irq_pin, irq_line};
			BWC_OFS_EVT_STATUS: next_rdata = {{(32-BWC_EVT_W){1'b0}}, evt_status};
			BWC_OFS_EVT_MASK: next_rdata = {{(32-BWC_EVT_W){1'b0}}, evt_mask};
			default: rd_mapped = 1'b0;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= '0;
			s_axi_rresp_out <= BWC_RESP_OKAY;
		end
		else
		begin
			s_axi_arready_out <= !s_axi_rvalid_out && !rd_fire;
			if (rd_fire)
			begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= next_rdata;
				s_axi_rresp_out <= rd_mapped ? BWC_RESP_OKAY : BWC_RESP_SLVERR;
			end
			else if (s_axi_rready_in)
				s_axi_rvalid_out <= 1'b0;
		end
	end

	// Forwarding decision, registered one cycle after the request.
	logic [63:0] pf_base_full;
	logic [63:0] pf_limit_full;
	logic [31:0] io_base_full;
	logic [31:0] io_limit_full;
	logic in_pf_win;
	logic in_io_win;
	logic io_low64k;
	logic isa_alias;
	logic vga_mem;
	logic vga_io;
	logic next_down;
	logic next_up;

	always_comb
	begin
		pf_base_full = {pf_base_hi, pf_base_low_in, 20'h0_0000};
		pf_limit_full = {pf_limit_hi, pf_limit_low_in, BWC_PF_LIMIT_LOW};
		io_base_full = {io_base_hi, io_base_low_in, 12'h000};
		io_limit_full = {io_limit_hi, io_limit_low_in, 12'hfff};
		in_pf_win = req_addr_in >= pf_base_full && req_addr_in <= pf_limit_full;
		in_io_win = req_addr_in[63:32] == 32'h0000_0000 && req_addr_in[31:0] >= io_base_full
			&& req_addr_in[31:0] <= io_limit_full;
		io_low64k = req_addr_in < {32'h0000_0000, BWC_IO_64K};
		isa_alias = io_low64k && req_addr_in[9:8] != 2'b00;
		vga_mem = req_addr_in >= BWC_VGA_MEM_LO && req_addr_in <= BWC_VGA_MEM_HI;
		vga_io = io_low64k && ((req_addr_in[9:0] >= BWC_VGA_IO_A_LO && req_addr_in[9:0] <= BWC_VGA_IO_A_HI)
			|| (req_addr_in[9:0] >= BWC_VGA_IO_B_LO && req_addr_in[9:0] <= BWC_VGA_IO_B_HI));
		next_down = 1'b0;
		next_up = 1'b0;
		if (req_is_io_in)
		begin
			if (ctrl[BWC_CTRL_VGA-BWC_CTRL_POISON] && vga_io)
				next_down = 1'b1;
			else if (in_io_win && ctrl[BWC_CTRL_ISA-BWC_CTRL_POISON] && isa_alias)
				next_up = 1'b1;
			else if (in_io_win)
				next_down = 1'b1;
		end
		else
			next_down = in_pf_win || (ctrl[BWC_CTRL_VGA-BWC_CTRL_POISON] && vga_mem);
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			fwd_valid_out <= 1'b0;
			fwd_down_out <= 1'b0;
			fwd_up_out <= 1'b0;
		end
		else
		begin
			fwd_valid_out <= req_valid_in;
			fwd_down_out <= req_valid_in && next_down;
			fwd_up_out <= req_valid_in && next_up;
		end
	end

	// Error and poisoned TLP handling on the secondary side.
	logic [BWC_EVT_W-1:0] evt_set;

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			poison_report_out <= 1'b0;
			err_msg_forward_out <= 1'b0;
		end
		else
		begin
			poison_report_out <= poisoned_tlp_in && ctrl[0];
			err_msg_forward_out <= err_msg_valid_in && ctrl[BWC_CTRL_ERRFWD-BWC_CTRL_POISON];
		end
	end

	always_comb
	begin
		evt_set = '0;
		evt_set[BWC_EVT_POISON] = poisoned_tlp_in && ctrl[0];
		evt_set[BWC_EVT_ERRFWD] = err_msg_valid_in && ctrl[BWC_CTRL_ERRFWD-BWC_CTRL_POISON];
		evt_set[BWC_EVT_ERRBLK] = err_msg_valid_in && !ctrl[BWC_CTRL_ERRFWD-BWC_CTRL_POISON];
		evt_set[BWC_EVT_HOTPLUG] = hotplug_event_in;
	end

	// Sticky status cleared by a read; an event in the clearing cycle survives.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			evt_status <= '0;
		else if (rd_fire && s_axi_araddr_in == BWC_OFS_EVT_STATUS)
			evt_status <= evt_set;
		else
			evt_status <= evt_status | evt_set;
	end

	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			evt_mask <= BWC_RST_MASK;
		else if (wr_fire && aw_addr == BWC_OFS_EVT_MASK && w_strb[0])
			evt_mask <= w_data[BWC_EVT_W-1:0];
	end

	// The interrupt output stands for the INTA virtual wire.
	always_ff @(posedge ref_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_out <= 1'b0;
			pf_addr_cap_out <= '0;
		end
		else
		begin
			irq_out <= |(evt_status & evt_mask);
			pf_addr_cap_out <= BWC_PF_ADDR64;
		end
	end
endmodule

// file: bwc_monitor.sv
/* Port checker for the bridge window register bank.
   Bound to each bwc_regs instance; one clock domain, reset active low. */
`timescale 1ns/1ps
module bwc_monitor
	import bwc_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rstn_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic req_valid_in,
	input wire logic fwd_valid_out,
	input wire logic fwd_down_out,
	input wire logic fwd_up_out,
	input wire logic poisoned_tlp_in,
	input wire logic poison_report_out,
	input wire logic err_msg_valid_in,
	input wire logic err_msg_forward_out,
	input wire logic [3:0] pf_addr_cap_out
);
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (!rstn_in);
	sequence s_wr_take;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	property p_wr_resp;
		s_wr_take |-> ##[1:2] s_axi_bvalid_out;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("no write response");
	property p_b_done;
		s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write response repeated");
	property p_rd_resp;
		s_rd_take |-> ##[1:2] s_axi_rvalid_out;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("no read data");
	property p_fwd_pulse;
		fwd_valid_out == $past(req_valid_in);
	endproperty
	a_fwd_pulse: assert property (p_fwd_pulse) else $error("decision not one cycle after request");
	property p_fwd_dir;
		fwd_down_out || fwd_up_out |-> fwd_valid_out && (fwd_down_out != fwd_up_out);
	endproperty
	a_fwd_dir: assert property (p_fwd_dir) else $error("bad forwarding direction");
	property p_poison;
		poison_report_out |-> $past(poisoned_tlp_in);
	endproperty
	a_poison: assert property (p_poison) else $error("poison report without cause");
	property p_err;
		err_msg_forward_out |-> $past(err_msg_valid_in);
	endproperty
	a_err: assert property (p_err) else $error("error forward without message");
	property p_cap;
		$past(rstn_in) |-> pf_addr_cap_out == BWC_PF_ADDR64;
	endproperty
	a_cap: assert property (p_cap) else $error("addressing field wrong");
endmodule

bind bwc_regs bwc_monitor u_mon (.ref_clk_in, .rstn_in, .s_axi_awvalid_in, .s_axi_awready_out,
	.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_arvalid_in,
	.s_axi_arready_out, .s_axi_rvalid_out, .req_valid_in, .fwd_valid_out, .fwd_down_out, .fwd_up_out,
	.poisoned_tlp_in, .poison_report_out, .err_msg_valid_in, .err_msg_forward_out, .pf_addr_cap_out);

// file: bwc_far_end.sv
/* Far-side model: request and event source standing for the attached links.
   Driven by task calls from the testbench; shares the register bank clock. */
`timescale 1ns/1ps
module bwc_far_end
(
	input wire logic ref_clk_in,
	input wire logic fwd_valid_in,
	input wire logic fwd_down_in,
	input wire logic fwd_up_in,
	input wire logic poison_report_in,
	input wire logic err_msg_forward_in,
	output logic req_valid_out,
	output logic req_is_io_out,
	output logic [63:0] req_addr_out,
	output logic [3:0] evt_out,
	output logic [7:0] pin_value_out
);
	initial
	begin
		{req_valid_out, req_is_io_out, req_addr_out, evt_out, pin_value_out} = '0;
	end
	task automatic send(input logic io, input logic [63:0] a, output logic [2:0] r);
		req_is_io_out <= io;
		req_addr_out <= a;
		req_valid_out <= 1'b1;
		@(posedge ref_clk_in);
		// Idle lines show the inverse so a stale address can never pass for a live one.
		req_valid_out <= 1'b0;
		req_is_io_out <= ~io;
		req_addr_out <= ~a;
		#1 r = {fwd_valid_in, fwd_down_in, fwd_up_in};
		@(posedge ref_clk_in);
	endtask
	task automatic pulse(input logic [3:0] k, input logic [7:0] v, output logic [1:0] r);
		evt_out <= k;
		pin_value_out <= v;
		@(posedge ref_clk_in);
		evt_out <= 4'h0;
		pin_value_out <= ~v;
		#1 r = {poison_report_in, err_msg_forward_in};
		@(posedge ref_clk_in);
	endtask
endmodule

// file: bwc_testbench.sv
/* Self-checking bench for the bridge window register bank.
   AXI4-Lite master tasks here; requests and events come from the far-side model. */
`timescale 1ns/1ps
module testbench
	import bwc_pkg::*;
;
	typedef struct packed {logic [3:0] c; logic io; logic [63:0] a; logic [2:0] e;} bwc_fcase_t;
	logic ref_clk_in, rstn_in;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in, pin_load_value_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [3:0] s_axi_wstrb_in, pf_addr_cap_out, io_base_low_in, io_limit_low_in;
	logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, irq_out;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
	logic [11:0] pf_base_low_in, pf_limit_low_in;
	logic req_valid_in, req_is_io_in, fwd_valid_out, fwd_down_out, fwd_up_out, poison_report_out, err_msg_forward_out;
	logic [63:0] req_addr_in;
	wire poisoned_tlp_in, err_msg_valid_in, hotplug_event_in, pin_load_valid_in;
	logic [2:0] fr;
	int failures, compares;
	bwc_fcase_t fc[16];
	bwc_regs dut (.ref_clk_in, .rstn_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
		.s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
		.s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .pf_base_low_in,
		.pf_limit_low_in, .io_base_low_in, .io_limit_low_in, .req_valid_in, .req_is_io_in, .req_addr_in,
		.fwd_valid_out, .fwd_down_out, .fwd_up_out, .poisoned_tlp_in, .poison_report_out, .err_msg_valid_in,
		.err_msg_forward_out, .hotplug_event_in, .pin_load_valid_in, .pin_load_value_in, .pf_addr_cap_out,
		.irq_out);
	bwc_far_end far (.ref_clk_in, .fwd_valid_in(fwd_valid_out), .fwd_down_in(fwd_down_out), .fwd_up_in(fwd_up_out),
		.poison_report_in(poison_report_out), .err_msg_forward_in(err_msg_forward_out), .req_valid_out(req_valid_in),
		.req_is_io_out(req_is_io_in), .req_addr_out(req_addr_in), .pin_value_out(pin_load_value_in),
		.evt_out({pin_load_valid_in, hotplug_event_in, err_msg_valid_in, poisoned_tlp_in}));
	initial
	begin
		ref_clk_in = 1'b0;
		forever #4 ref_clk_in = ~ref_clk_in;
	end
	task automatic print_verdict();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		failures++;
		print_verdict();
	end
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er = BWC_RESP_OKAY);
		logic ka, kw, b;
		int n;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= s;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 40 && !b; n++)
		begin
			@(negedge ref_clk_in);
			ka = s_axi_awvalid_in & s_axi_awready_out;
			kw = s_axi_wvalid_in & s_axi_wready_out;
			b = s_axi_bvalid_out;
			if (b)
				chk({s_axi_bresp_out, 32'h0000_0000}, {er, 32'h0000_0000});
			@(posedge ref_clk_in);
			if (ka)
				s_axi_awvalid_in <= 1'b0;
			if (kw)
				s_axi_wvalid_in <= 1'b0;
		end
		s_axi_bready_in <= 1'b0;
		if (!b)
			chk(34'h0, 34'h1);
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = BWC_RESP_OKAY);
		logic ka, b;
		int n;
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		b = 1'b0;
		for (n = 0; n < 40 && !b; n++)
		begin
			@(negedge ref_clk_in);
			ka = s_axi_arvalid_in & s_axi_arready_out;
			b = s_axi_rvalid_out;
			if (b)
				chk({s_axi_rresp_out, s_axi_rdata_out}, {er, e});
			@(posedge ref_clk_in);
			if (ka)
				s_axi_arvalid_in <= 1'b0;
		end
		s_axi_rready_in <= 1'b0;
		if (!b)
			chk(34'h0, 34'h1);
		@(posedge ref_clk_in);
	endtask
	task automatic do_reset();
		rstn_in <= 1'b0;
		repeat (2) @(posedge ref_clk_in);
		rstn_in <= 1'b1;
		@(posedge ref_clk_in);
	endtask
	initial
	begin
		{rstn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, s_axi_wstrb_in} = '0;
		{pf_base_low_in, pf_limit_low_in, io_base_low_in, io_limit_low_in} = {12'h001, 12'h002, 4'h1, 4'h2};
		failures = 0;
		compares = 0;
		fc = '{'{4'h0, 1'b0, 64'h1_0010_0000, 3'h6}, '{4'h0, 1'b0, 64'h1_002f_ffff, 3'h6},
			'{4'h0, 1'b0, 64'h1_0030_0000, 3'h4}, '{4'h0, 1'b0, 64'h0_0010_0000, 3'h4},
			'{4'h0, 1'b0, 64'h000a_0000, 3'h4}, '{4'h8, 1'b0, 64'h000a_0000, 3'h6},
			'{4'h8, 1'b0, 64'h000b_ffff, 3'h6}, '{4'h8, 1'b0, 64'h000c_0000, 3'h4},
			'{4'h0, 1'b1, 64'h1000, 3'h6}, '{4'h0, 1'b1, 64'h2fff, 3'h6}, '{4'h0, 1'b1, 64'h13ff, 3'h6},
			'{4'h4, 1'b1, 64'h13ff, 3'h5}, '{4'h4, 1'b1, 64'h1000, 3'h6}, '{4'h8, 1'b1, 64'h03bb, 3'h6},
			'{4'h8, 1'b1, 64'h03bc, 3'h4}, '{4'h8, 1'b1, 64'h03df, 3'h6}};
		do_reset();
		rd(BWC_OFS_PF_BASE_HI, 32'h0000_0000);
		rd(BWC_OFS_PF_LIMIT_HI, 32'h0000_0000);
		rd(BWC_OFS_IO_HI, 32'h0000_0000);
		rd(BWC_OFS_IRQ_CTRL, 32'h0000_0000);
		rd(BWC_OFS_EVT_MASK, 32'h0000_0000);
		chk({30'h0, pf_addr_cap_out}, {30'h0, BWC_PF_ADDR64});
		wr(BWC_OFS_PF_BASE_HI, 32'hffff_ffff, 4'hf);
		rd(BWC_OFS_PF_BASE_HI, 32'hffff_ffff);
		wr(BWC_OFS_PF_LIMIT_HI, 32'ha5a5_5a5a, 4'hf);
		rd(BWC_OFS_PF_LIMIT_HI, 32'ha5a5_5a5a);
		wr(BWC_OFS_IO_HI, 32'h1234_5678, 4'h3);
		rd(BWC_OFS_IO_HI, 32'h0000_5678);
		wr(BWC_OFS_IO_HI, 32'habcd_0000, 4'hc);
		rd(BWC_OFS_IO_HI, 32'habcd_5678);
		wr(BWC_OFS_CAP_PTR, 32'hffff_ffff, 4'hf);
		rd(BWC_OFS_CAP_PTR, 32'h0000_0040);
		wr(8'h40, 32'hffff_ffff, 4'hf, BWC_RESP_SLVERR);
		rd(8'h40, 32'h0000_0000, BWC_RESP_SLVERR);
		wr(BWC_OFS_IRQ_CTRL, 32'hffff_ffa5, 4'hf);
		rd(BWC_OFS_IRQ_CTRL, 32'h000f_00a5);
		wr(BWC_OFS_PF_BASE_HI, 32'h0000_0001, 4'hf);
		wr(BWC_OFS_PF_LIMIT_HI, 32'h0000_0001, 4'hf);
		wr(BWC_OFS_IO_HI, 32'h0000_0000, 4'hf);
		foreach (fc[i])
		begin
			wr(BWC_OFS_IRQ_CTRL, {12'h000, fc[i].c, 16'h0000}, 4'h4);
			far.send(fc[i].io, fc[i].a, fr);
			chk({31'h0, fr}, {31'h0, fc[i].e});
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(BWC_OFS_IRQ_CTRL, {12'h000, 2'b00, i == 3, i == 1, 16'h0000}, 4'h4);
			far.pulse(i < 2 ? 4'h1 : 4'h2, 8'h00, rs);
			chk({32'h0, rs}, {32'h0, i == 1, i == 3});
		end
		chk({33'h0, irq_out}, 34'h0);
		rd(BWC_OFS_EVT_STATUS, 32'h0000_0007);
		rd(BWC_OFS_EVT_STATUS, 32'h0000_0000);
		wr(BWC_OFS_EVT_MASK, 32'h0000_0008, 4'hf);
		far.pulse(4'h4, 8'h00, rs);
		@(negedge ref_clk_in);
		chk({33'h0, irq_out}, 34'h1);
		@(posedge ref_clk_in);
		rd(BWC_OFS_EVT_STATUS, 32'h0000_0008);
		chk({33'h0, irq_out}, 34'h0);
		do_reset();
		rd(BWC_OFS_PF_BASE_HI, 32'h0000_0000);
		far.pulse(4'h8, 8'h01, rs);
		rd(BWC_OFS_IRQ_CTRL, 32'h0000_0100);
		far.pulse(4'h8, 8'h02, rs);
		rd(BWC_OFS_IRQ_CTRL, 32'h0000_0100);
		print_verdict();
	end
endmodule
